// ---- shared/dtc_pkg.sv ----
// Purpose: shared constants and types for the dynamic termination link
// Assumes: one memory clock; latencies counted in whole clock cycles
// Notes: mode register fields carry the termination selections
package dtc_pkg;
	// mode register field positions
	localparam int MR1_NOM_BIT2 = 2;
	localparam int MR1_NOM_BIT6 = 6;
	localparam int MR1_NOM_BIT9 = 9;
	localparam int MR2_WR_BIT9 = 9;
	localparam int MR2_WR_BIT10 = 10;
	localparam logic [15:0] MR1_RESET = 16'h0000;
	localparam logic [15:0] MR2_RESET = 16'h0000;
	// latency arithmetic
	localparam logic [5:0] LAT_OFFSET = 6'h02;
	localparam logic [5:0] CWN_CHOP_ADD = 6'h04;
	localparam logic [5:0] CWN_FULL_ADD = 6'h06;
	localparam logic [5:0] MIN_PIN_HIGH_SHORT = 6'h04;
	localparam logic [5:0] MIN_PIN_HIGH_LONG = 6'h06;
	localparam logic [5:0] WRITE_LATENCY_RESET = 6'h05;
	localparam logic [5:0] ADDITIVE_LATENCY_RESET = 6'h00;
	// strength change skew, tenths of a clock period
	localparam int STRENGTH_CHANGE_SKEW_MIN_TENTHS = 3;
	localparam int STRENGTH_CHANGE_SKEW_MAX_TENTHS = 7;
	localparam int STRENGTH_CHANGE_NOM_TENTHS = 5;
	localparam int DELAY_DEPTH = 64;
	localparam int CNT_W = 6;

	typedef enum logic [1:0] {
		DTC_CMD_NONE,
		DTC_CMD_WRITE,
		DTC_CMD_MRS1,
		DTC_CMD_MRS2
	} dtc_cmd_e;

	typedef enum logic [1:0] {
		DTC_BURST_MR,
		DTC_BURST_CHOP,
		DTC_BURST_FULL
	} dtc_burst_e;

	typedef enum logic [1:0] {
		DTC_RTT_OFF,
		DTC_RTT_NOM,
		DTC_RTT_WR
	} dtc_rtt_e;

	function automatic logic [CNT_W-1:0] dtc_term_latency(input logic [CNT_W-1:0] cwl,
			input logic [CNT_W-1:0] al);
		dtc_term_latency = cwl + al - LAT_OFFSET;
	endfunction
endpackage

// ---- shared/dtc_link_if.sv ----
// Purpose: link between memory controller and termination logic
// Assumes: all signals sampled on rising memory clock
// Notes: command, burst, address and pin level travel together
`timescale 1ns/10ps
interface dtc_link_if (
	input wire logic i_sys_clk
);
	import dtc_pkg::*;
	logic odt_pin;
	dtc_cmd_e cmd;
	dtc_burst_e burst;
	logic [15:0] addr;
	logic self_refresh;
	logic dll_off;

	modport controller (
		output odt_pin,
		output cmd,
		output burst,
		output addr,
		output self_refresh,
		output dll_off
	);
	modport device (
		input odt_pin,
		input cmd,
		input burst,
		input addr,
		input self_refresh,
		input dll_off
	);
endinterface

// ---- logic/dtc_shift_delay.sv ----
// Purpose: variable delay line for one bit, tap set by latency
// Assumes: latency below the line depth
// Notes: a latency of zero passes the input through
`timescale 1ns/10ps
module dtc_shift_delay (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_bit,
	input wire logic [dtc_pkg::CNT_W-1:0] i_latency,
	output logic o_bit
);
	import dtc_pkg::*;
	logic [DELAY_DEPTH-1:0] line;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			line <= '0;
		end else begin
			line <= {line[DELAY_DEPTH-2:0], i_bit};
		end
	end

	always_comb begin
		if (i_latency == '0) begin
			o_bit = i_bit;
		end else begin
			o_bit = line[i_latency - 6'h01];
		end
	end
endmodule

// ---- logic/dtc_device.sv ----
// Purpose: on-die termination strength control inside the memory device
// Assumes: controller keeps its own minimum pin-high times
// Notes: half-cycle change delay is modelled by the analog output stage
// What this block does
// - strength switches without mode register writes
// - dynamic switching on if either write bit set
// - nominal value from first register bits
// - write value from second register bits
// - nominal strength; pin gates on/off with latency
// - write strength after nominal-to-write latency
// - return to nominal, chop or full latency
// - nominal-to-write latency equals write latency minus two
// - chop return latency is off latency plus four
// - full return latency is off latency plus six
// - controller clears write bits when DLL off
// - controller holds pin high four cycles
// - write with pin high holds four/six cycles
// - both hold bounds checked; later one governs
// - strength valid 0.3 to 0.7 cycle after
// - nominal change and off delay half cycle
// - on and off latency write latency minus two
// - write latency includes additive latency
// - pin ignored when disabled or self-refresh
`timescale 1ns/10ps
module dtc_device (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	dtc_link_if.device link,
	input wire logic [dtc_pkg::CNT_W-1:0] i_cas_write_latency,
	input wire logic [dtc_pkg::CNT_W-1:0] i_additive_latency,
	input wire logic i_mr_burst_chop,
	output logic o_term_on,
	output dtc_pkg::dtc_rtt_e o_rtt_sel,
	output logic [2:0] o_rtt_nom_code,
	output logic [1:0] o_rtt_wr_code,
	output logic o_dyn_enable
);
	import dtc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// mode registers
	// a mode register set command loads the whole address word
	logic [15:0] mr1;
	logic [15:0] mr2;
	logic [2:0] nom_code;
	logic [1:0] wr_code;
	logic dyn_en;
	logic term_enabled;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mr1 <= MR1_RESET;
		end else if (link.cmd == DTC_CMD_MRS1) begin
			mr1 <= link.addr;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mr2 <= MR2_RESET;
		end else if (link.cmd == DTC_CMD_MRS2) begin
			mr2 <= link.addr;
		end
	end

	assign nom_code = {mr1[MR1_NOM_BIT9], mr1[MR1_NOM_BIT6], mr1[MR1_NOM_BIT2]};
	assign wr_code = {mr2[MR2_WR_BIT10], mr2[MR2_WR_BIT9]};
	assign dyn_en = |wr_code;
	assign term_enabled = (|nom_code) || dyn_en;

	////////////////////////////////////////////////////////////////////////
	// latencies
	logic [CNT_W-1:0] on_off_lat;
	logic [CNT_W-1:0] cwn_lat;
	logic chop;

	assign on_off_lat = dtc_term_latency(i_cas_write_latency, i_additive_latency);
	always_comb begin
		unique case (link.burst)
			DTC_BURST_CHOP: chop = 1'b1;
			DTC_BURST_FULL: chop = 1'b0;
			default: chop = i_mr_burst_chop;
		endcase
	end
	// return latency from the write: chop adds four cycles, a full burst six
	assign cwn_lat = chop ? (on_off_lat + CWN_CHOP_ADD) : (on_off_lat + CWN_FULL_ADD);

	////////////////////////////////////////////////////////////////////////
	// pin path with on/off latency
	logic pin_eff;
	logic pin_late;

	// pin ignored with both registers clear or in self-refresh
	assign pin_eff = link.odt_pin && term_enabled && !link.self_refresh;

	dtc_shift_delay u_pin_delay (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_bit(pin_eff),
		.i_latency(on_off_lat),
		.o_bit(pin_late)
	);

	////////////////////////////////////////////////////////////////////////
	// write window: start after cnw, end cwn after latest write
	logic wr_cmd;
	logic cnw_hit;
	logic [CNT_W-1:0] cwn_left;
	logic wr_active;

	// writes only open the window while switching is on and the DLL runs
	assign wr_cmd = (link.cmd == DTC_CMD_WRITE) && dyn_en && !link.dll_off;

	// the write bit rides a delay line as long as the pin path
	dtc_shift_delay u_cnw_delay (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_bit(wr_cmd),
		.i_latency(on_off_lat),
		.o_bit(cnw_hit)
	);

	// countdown from each write; a later write reloads it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cwn_left <= '0;
		end else if (wr_cmd) begin
			cwn_left <= cwn_lat - 6'h01;
		end else if (cwn_left != '0) begin
			cwn_left <= cwn_left - 6'h01;
		end
	end

	// window holds from the delayed write bit to the last count;
	// losing the enable closes it at once
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_active <= 1'b0;
		end else if (!dyn_en || (cwn_left == 6'h01 && !wr_cmd)) begin
			wr_active <= 1'b0;
		end else if (cnw_hit) begin
			wr_active <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, registered; analog stage adds the half-cycle skew
	logic term_now;
	logic wr_strength;
	dtc_rtt_e next_rtt_sel;

	// self-refresh drops termination at once, without waiting for the delay line
	assign term_now = pin_late && !link.self_refresh;
	// the delayed write bit is used directly, so a pin raised with the write
	// turns on straight at write strength, both after the same latency
	assign wr_strength = dyn_en && (wr_active || cnw_hit);

	always_comb begin
		if (!term_now) begin
			next_rtt_sel = DTC_RTT_OFF;
		end else if (wr_strength) begin
			next_rtt_sel = DTC_RTT_WR;
		end else begin
			next_rtt_sel = DTC_RTT_NOM;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_term_on <= 1'b0;
		end else begin
			o_term_on <= term_now;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rtt_sel <= DTC_RTT_OFF;
		end else begin
			o_rtt_sel <= next_rtt_sel;
		end
	end

	// selected codes are mirrored for the analog stage
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rtt_nom_code <= 3'h0;
		end else begin
			o_rtt_nom_code <= nom_code;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rtt_wr_code <= 2'h0;
		end else begin
			o_rtt_wr_code <= wr_code;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dyn_enable <= 1'b0;
		end else begin
			o_dyn_enable <= dyn_en;
		end
	end
endmodule

// ---- logic/dtc_controller.sv ----
// Purpose: controller end driving commands and the termination pin
// Assumes: user asks for pin high and issues commands one per cycle
// Notes: pin release is held off until both hold times run out
`timescale 1ns/10ps
module dtc_controller (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	dtc_link_if.controller link,
	input wire logic i_odt_req,
	input wire dtc_pkg::dtc_cmd_e i_cmd,
	input wire dtc_pkg::dtc_burst_e i_burst,
	input wire logic i_mr_burst_chop,
	input wire logic [15:0] i_addr,
	input wire logic i_self_refresh,
	input wire logic i_dll_off,
	output logic o_pin_held
);
	import dtc_pkg::*;
	logic [CNT_W-1:0] hold_left;
	logic chop;
	logic [CNT_W-1:0] wr_hold;
	logic is_wr;
	logic [15:0] addr_out;

	always_comb begin
		unique case (i_burst)
			DTC_BURST_CHOP: chop = 1'b1;
			DTC_BURST_FULL: chop = 1'b0;
			default: chop = i_mr_burst_chop;
		endcase
	end
	assign wr_hold = chop ? MIN_PIN_HIGH_SHORT : MIN_PIN_HIGH_LONG;
	assign is_wr = (i_cmd == DTC_CMD_WRITE);

	// with DLL off, force write termination bits to zero
	always_comb begin
		addr_out = i_addr;
		if (i_cmd == DTC_CMD_MRS2 && i_dll_off) begin
			addr_out[MR2_WR_BIT10] = 1'b0;
			addr_out[MR2_WR_BIT9] = 1'b0;
		end
	end

	// hold counter: cycles the pin must still stay high after this one
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_left <= '0;
			link.odt_pin <= 1'b0;
		end else begin
			if (!link.odt_pin) begin
				if (i_odt_req || is_wr) begin
					link.odt_pin <= i_odt_req;
					// a write launched with the rise takes the longer of both holds
					if (!i_odt_req) begin
						hold_left <= '0;
					end else if (is_wr && wr_hold > MIN_PIN_HIGH_SHORT) begin
						hold_left <= wr_hold - 6'h01;
					end else begin
						hold_left <= MIN_PIN_HIGH_SHORT - 6'h01;
					end
				end
			end else begin
				if (is_wr && (wr_hold - 6'h01) > hold_left) begin
					hold_left <= wr_hold - 6'h01;
				end else if (hold_left != '0) begin
					hold_left <= hold_left - 6'h01;
				end
				if (!i_odt_req && hold_left == '0 && !is_wr) begin
					link.odt_pin <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link.cmd <= DTC_CMD_NONE;
			link.burst <= DTC_BURST_MR;
			link.addr <= 16'h0000;
			link.self_refresh <= 1'b0;
			link.dll_off <= 1'b0;
		end else begin
			link.cmd <= i_cmd;
			link.burst <= i_burst;
			link.addr <= addr_out;
			link.self_refresh <= i_self_refresh;
			link.dll_off <= i_dll_off;
		end
	end

	assign o_pin_held = link.odt_pin && (hold_left != '0);
endmodule

// ---- tb/dtc_link_assertions.sv ----
// Purpose: timing checks on the termination link
// Assumes: latency setting fixed for the run
// Notes: watches link signals and device outputs
`timescale 1ns/10ps
module dtc_link_assertions #(
	parameter int LAT = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic odt_pin,
	input wire dtc_pkg::dtc_cmd_e cmd,
	input wire dtc_pkg::dtc_burst_e burst,
	input wire logic [15:0] addr,
	input wire logic self_refresh,
	input wire logic dll_off,
	input wire logic o_term_on,
	input wire dtc_pkg::dtc_rtt_e o_rtt_sel,
	input wire logic [2:0] o_rtt_nom_code,
	input wire logic [1:0] o_rtt_wr_code,
	input wire logic o_dyn_enable
);
	import dtc_pkg::*;
	logic en;
	assign en = (|{o_rtt_nom_code, o_rtt_wr_code}) && !self_refresh;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////
	sequence wr_s(b);
		cmd == DTC_CMD_WRITE && odt_pin && o_dyn_enable && !self_refresh && !dll_off
			&& burst == b;
	endsequence
	sequence quiet_s;
		cmd != DTC_CMD_WRITE && odt_pin;
	endsequence
	pin_hold_short_a: assert property ($rose(odt_pin) |-> odt_pin[*4])
		else $error("pin dropped early after rise");
	pin_hold_full_a: assert property (cmd == DTC_CMD_WRITE && odt_pin && burst == DTC_BURST_FULL
		|-> odt_pin[*6]) else $error("pin dropped early after write");
	term_rise_a: assert property ($rose(odt_pin) && en |-> ##LAT !o_term_on ##1 o_term_on)
		else $error("termination on at wrong cycle");
	term_fall_a: assert property ($fell(odt_pin) && en |-> ##LAT o_term_on ##1 !o_term_on)
		else $error("termination off at wrong cycle");
	rtt_wr_a: assert property (wr_s(DTC_BURST_FULL) or wr_s(DTC_BURST_CHOP)
		|-> ##(LAT+1) o_rtt_sel == DTC_RTT_WR) else $error("write strength late");
	rtt_full_a: assert property (wr_s(DTC_BURST_FULL) ##1 quiet_s[*5]
		|-> ##(LAT+1) o_rtt_sel == DTC_RTT_WR ##1 o_rtt_sel != DTC_RTT_WR)
		else $error("full return");
	rtt_chop_a: assert property (wr_s(DTC_BURST_CHOP) ##1 quiet_s[*3]
		|-> ##(LAT+1) o_rtt_sel == DTC_RTT_WR ##1 o_rtt_sel != DTC_RTT_WR)
		else $error("chop return");
	wr_code_a: assert property (cmd == DTC_CMD_MRS2 |-> ##2 o_rtt_wr_code
		== $past(addr[10:9], 2) && o_dyn_enable == (|$past(addr[10:9], 2)))
		else $error("write code or enable wrong");
	nom_code_a: assert property (cmd == DTC_CMD_MRS1 |-> ##2 o_rtt_nom_code
		== {$past(addr[9], 2), $past(addr[6], 2), $past(addr[2], 2)})
		else $error("nominal code wrong");
	dll_clear_a: assert property (dll_off && cmd == DTC_CMD_MRS2 |-> addr[10:9] == 2'h0)
		else $error("write bits kept with dll off");
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for both link ends
// Assumes: write plus additive latency stays 5 (5+0, later 4+1)
// Notes: counts pin, on and write-strength cycles
`timescale 1ns/10ps
module tb;
	import dtc_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_odt_req = 1'b0;
	dtc_cmd_e i_cmd = DTC_CMD_NONE;
	dtc_burst_e i_burst = DTC_BURST_MR;
	logic i_mr_burst_chop = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic i_self_refresh = 1'b0;
	logic i_dll_off = 1'b0;
	logic [5:0] cwl = 6'h05;
	logic [5:0] al = 6'h00;
	logic o_pin_held;
	logic o_term_on;
	logic o_dyn_enable;
	dtc_rtt_e o_rtt_sel;
	logic [2:0] o_rtt_nom_code;
	logic [1:0] o_rtt_wr_code;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int n_pin;
	int n_on;
	int n_wr;
	int n_held;
	dtc_link_if u_link (.i_sys_clk(i_sys_clk));
	dtc_controller u_dtc_controller (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(u_link),
		.i_odt_req(i_odt_req), .i_cmd(i_cmd), .i_burst(i_burst), .i_mr_burst_chop(i_mr_burst_chop),
		.i_addr(i_addr), .i_self_refresh(i_self_refresh), .i_dll_off(i_dll_off),
		.o_pin_held(o_pin_held));
	dtc_device u_dtc_device (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(u_link),
		.i_cas_write_latency(cwl), .i_additive_latency(al), .i_mr_burst_chop(i_mr_burst_chop),
		.o_term_on(o_term_on), .o_rtt_sel(o_rtt_sel), .o_rtt_nom_code(o_rtt_nom_code),
		.o_rtt_wr_code(o_rtt_wr_code), .o_dyn_enable(o_dyn_enable));
	dtc_link_assertions #(.LAT(3)) u_dtc_link_assertions (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .odt_pin(u_link.odt_pin), .cmd(u_link.cmd), .burst(u_link.burst),
		.addr(u_link.addr), .self_refresh(u_link.self_refresh), .dll_off(u_link.dll_off),
		.o_term_on(o_term_on), .o_rtt_sel(o_rtt_sel), .o_rtt_nom_code(o_rtt_nom_code),
		.o_rtt_wr_code(o_rtt_wr_code), .o_dyn_enable(o_dyn_enable));
	////////////////////////////////////////
	task automatic complete_run();
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic cmd_go(input dtc_cmd_e c, input dtc_burst_e b, input logic [15:0] a,
			input logic req);
		@(posedge i_sys_clk);
		i_cmd <= c;
		i_burst <= b;
		i_addr <= a;
		i_odt_req <= req;
		@(posedge i_sys_clk);
		i_cmd <= DTC_CMD_NONE;
		i_odt_req <= 1'b0;
	endtask
	task automatic watch(input int n);
		n_pin = 0;
		n_on = 0;
		n_wr = 0;
		n_held = 0;
		repeat (n) begin
			@(negedge i_sys_clk);
			n_pin += int'(u_link.odt_pin === 1'b1);
			n_on += int'(o_term_on === 1'b1);
			n_wr += int'(o_rtt_sel === DTC_RTT_WR);
			n_held += int'(o_pin_held === 1'b1);
		end
	endtask
	// one pin request, optionally with a command, and if two is set a second one two cycles later
	task automatic t_pulse(input dtc_cmd_e c, input dtc_burst_e b, input logic two, input int ep,
			input int eo, input int ew);
		fork
			watch(24);
			begin
				cmd_go(c, b, 16'h0000, 1'b1);
				if (two) begin
					cmd_go(c, b, 16'h0000, 1'b1);
				end
			end
		join
		chk(n_pin == ep && n_on == eo && n_wr == ew && n_held == ep - 1,
			"pin, hold, on or write window count");
		@(posedge i_sys_clk);
	endtask
	task automatic t_mrs(input dtc_cmd_e c, input logic [15:0] a, input logic [5:0] e);
		cmd_go(c, DTC_BURST_MR, a, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk({o_rtt_nom_code, o_rtt_wr_code, o_dyn_enable} === e, "mode register decode");
		@(posedge i_sys_clk);
	endtask
	////////////////////////////////////////
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_mrs(DTC_CMD_MRS1, 16'h0204, 6'h28);
		t_mrs(DTC_CMD_MRS2, 16'h0400, 6'h2d);
		t_pulse(DTC_CMD_WRITE, DTC_BURST_FULL, 1'b0, 6, 6, 6);
		t_pulse(DTC_CMD_WRITE, DTC_BURST_CHOP, 1'b0, 4, 4, 4);
		i_mr_burst_chop <= 1'b1;
		t_pulse(DTC_CMD_WRITE, DTC_BURST_MR, 1'b0, 4, 4, 4);
		i_mr_burst_chop <= 1'b0;
		t_pulse(DTC_CMD_WRITE, DTC_BURST_FULL, 1'b1, 8, 8, 8);
		t_pulse(DTC_CMD_NONE, DTC_BURST_MR, 1'b0, 4, 4, 0);
		i_dll_off <= 1'b1;
		t_mrs(DTC_CMD_MRS2, 16'h0600, 6'h28);
		t_pulse(DTC_CMD_WRITE, DTC_BURST_FULL, 1'b0, 6, 6, 0);
		i_dll_off <= 1'b0;
		t_mrs(DTC_CMD_MRS2, 16'h0200, 6'h2b);
		cwl <= 6'h04;
		al <= 6'h01;
		t_pulse(DTC_CMD_WRITE, DTC_BURST_FULL, 1'b0, 6, 6, 6);
		i_self_refresh <= 1'b1;
		t_pulse(DTC_CMD_NONE, DTC_BURST_MR, 1'b0, 4, 0, 0);
		complete_run();
	end
endmodule
